// File: bench/uart_far_node.sv
// far serial node feeding frames and start edges to the receive side
// assumes one shared clock; idle receive line is pulled up
`timescale 1ns/1ps
module uart_far_node (
  // clock
  input  wire logic            clk,
  // link to the port
  output logic                 rx_pin,
  output uart_wake_pkg::rx_frame_type frame_in,
  output logic                 frame_busy,
  output logic                 false_start
);
  initial begin
    rx_pin = 1'b1;
    frame_in = '0;
    frame_busy = 1'b0;
    false_start = 1'b0;
  end
  // fake holds the start bit as long, then pulses false_start instead of a frame; released fields show inverted junk
  task automatic send_frame(input logic [8:0] d, input logic s1, input logic fake);
    @(posedge clk);
    rx_pin <= 1'b0;
    frame_busy <= 1'b1;
    repeat (12) @(posedge clk);
    rx_pin <= 1'b1;
    frame_busy <= 1'b0;
    if (fake) begin
      false_start <= 1'b1;
      @(posedge clk);
      false_start <= 1'b0;
    end else begin
      frame_in <= '{1'b1, d, s1, ~s1, 1'b0};
      @(posedge clk);
      frame_in <= '{1'b0, ~d, ~s1, s1, 1'b1};
    end
  endtask
endmodule

// File: bench/uart_wake_tb_top.sv
// testbench: register tasks, far node frames, queued read checks
// assumes uart_wake and uart_far_node are compiled first
`timescale 1ns/1ps
module uart_wake_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_q = 1'b0;
  logic        txd = 1'b0;
  logic        abe = 1'b0;
  logic        tick = 1'b0;
  logic        taken = 1'b0;
  logic        standby = 1'b0;
  logic        sleep_req = 1'b0;
  logic        ir_in = 1'b0;
  logic [7:0]  rdata;
  logic        rx_pin, frame_busy, false_start, sco, irp, rxv, dev, tcv, osck;
  uart_wake_pkg::rx_frame_type frame_in;
  uart_wake_pkg::wake_out_type wake_out;
  logic [15:0] exp_q[$];
  logic [15:0] ent;
  int          n_fail = 0;
  int          num_checks = 0;
  int          seed = 32'ha9dd;
  logic [7:0]  cnt;
  logic [7:0]  d;
  always #2 clk = ~clk;
  uart_wake u_uart_wake (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx_pin(rx_pin), .frame_in(frame_in), .frame_busy(frame_busy),
    .false_start(false_start), .tx_shift_done(txd), .tx_buf_taken(taken),
    .autobaud_err(abe), .shift_clk_tick(tick), .standby(standby), .other_wake(1'b0),
    .sleep_req(sleep_req), .wake_out(wake_out), .osc_keep(osck),
    .infrared_event_input(ir_in), .shift_clock_output(sco), .ir_pulse(irp),
    .receive_irq_vector(rxv), .tx_empty_irq_vector(dev), .tx_done_irq_vector(tcv));
  uart_far_node u_uart_far_node (.clk(clk), .rx_pin(rx_pin), .frame_in(frame_in),
    .frame_busy(frame_busy), .false_start(false_start));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // expected value is queued; the monitor below compares it
  task automatic rd_exp(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after the strobe
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    if (rd_q) begin
      ent = exp_q.pop_front();
      chk("rdata", ent[7:0], rdata & ent[15:8]);
    end
  end
  initial begin
    #40000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_exp(4'h4, 8'hff, uart_wake_pkg::status_rst);
    rd_exp(4'hf, 8'hff, 8'h00);
    wr_reg(4'h5, 8'h60);
    rd_exp(4'h5, 8'hff, 8'h60);
    cyc(2);
    chk("dre_irq", 8'h01, {7'h0, dev});
    // a load empties nothing until the shifter takes the buffer
    wr_reg(4'h2, 8'h5a);
    cyc(2);
    chk("dre_irq", 8'h00, {7'h0, dev});
    @(posedge clk);
    taken <= 1'b1;
    @(posedge clk);
    taken <= 1'b0;
    cyc(3);
    chk("dre_irq", 8'h01, {7'h0, dev});
    @(posedge clk);
    txd <= 1'b1;
    @(posedge clk);
    txd <= 1'b0;
    cyc(3);
    chk("txc_irq", 8'h01, {7'h0, tcv});
    wr_reg(4'h4, 8'h40);
    cyc(3);
    chk("txc_irq", 8'h00, {7'h0, tcv});
    $display("test irq tx done");
    // filter mode, eight-bit frames carry type in the first stop bit
    wr_reg(4'h7, 8'h03);
    wr_reg(4'h6, 8'h01);
    d = 8'($random(seed));
    u_uart_far_node.send_frame({1'b0, d}, 1'b0, 1'b0);
    rd_exp(4'h4, 8'h80, 8'h00);
    u_uart_far_node.send_frame({1'b0, ~d}, 1'b1, 1'b0);
    rd_exp(4'h4, 8'h80, 8'h80);
    rd_exp(4'h0, 8'hff, ~d);
    wr_reg(4'h6, 8'h00);
    u_uart_far_node.send_frame({1'b0, d}, 1'b0, 1'b0);
    rd_exp(4'h0, 8'hff, d);
    // nine-bit frames take the type from the ninth bit
    wr_reg(4'h7, 8'h07);
    wr_reg(4'h6, 8'h01);
    u_uart_far_node.send_frame({1'b0, d}, 1'b1, 1'b0);
    rd_exp(4'h4, 8'h80, 8'h00);
    u_uart_far_node.send_frame({1'b1, d}, 1'b0, 1'b0);
    rd_exp(4'h1, 8'h01, 8'h01);
    rd_exp(4'h0, 8'hff, d);
    $display("test address filter done");
    wr_reg(4'h6, 8'h00);
    wr_reg(4'h5, 8'h80);
    u_uart_far_node.send_frame({1'b0, ~d}, 1'b0, 1'b0);
    cyc(3);
    chk("rx_irq", 8'h01, {7'h0, rxv});
    rd_exp(4'h0, 8'hff, ~d);
    cyc(3);
    chk("rx_irq", 8'h00, {7'h0, rxv});
    wr_reg(4'h5, 8'h04);
    @(posedge clk);
    abe <= 1'b1;
    @(posedge clk);
    abe <= 1'b0;
    cyc(3);
    chk("rx_irq", 8'h01, {7'h0, rxv});
    wr_reg(4'h4, 8'h08);
    cyc(3);
    chk("rx_irq", 8'h00, {7'h0, rxv});
    $display("test rx irq done");
    // standby wake: start irq enabled wakes at once, so a false start keeps it awake
    @(posedge clk);
    standby <= 1'b1;
    sleep_req <= 1'b1;
    wr_reg(4'h5, 8'h10);
    wr_reg(4'h7, 8'h03);
    wr_reg(4'h6, 8'h10);
    fork
      u_uart_far_node.send_frame(9'h000, 1'b1, 1'b1);
      begin
        cyc(10);
        chk("osc_req", 8'h01, {7'h0, wake_out.osc_req});
        chk("clk_en", 8'h01, {7'h0, wake_out.clk_en});
        chk("wake_irq", 8'h01, {7'h0, wake_out.wake_irq});
        chk("osc_keep", 8'h01, {7'h0, osck});
        chk("rx_irq", 8'h01, {7'h0, rxv});
      end
    join
    cyc(4);
    chk("osc_req", 8'h01, {7'h0, wake_out.osc_req});
    @(posedge clk);
    standby <= 1'b0;
    wr_reg(4'h5, 8'h00);
    standby <= 1'b1;
    // no irq enabled: oscillator only, released by the false start
    fork
      u_uart_far_node.send_frame(9'h000, 1'b1, 1'b1);
      begin
        cyc(10);
        chk("osc_req", 8'h01, {7'h0, wake_out.osc_req});
        chk("wake_irq", 8'h00, {7'h0, wake_out.wake_irq});
      end
    join
    cyc(4);
    chk("osc_req", 8'h00, {7'h0, wake_out.osc_req});
    rd_exp(4'h4, 8'h10, 8'h10);
    wr_reg(4'h4, 8'h10);
    rd_exp(4'h4, 8'h10, 8'h00);
    wr_reg(4'h7, 8'h43);
    fork
      u_uart_far_node.send_frame(9'h000, 1'b1, 1'b1);
      begin
        cyc(10);
        chk("osc_req", 8'h00, {7'h0, wake_out.osc_req});
      end
    join
    standby <= 1'b0;
    sleep_req <= 1'b0;
    $display("test wake done");
    // events: exactly one output pulse per input event
    wr_reg(4'hc, 8'h01);
    cnt = 8'h00;
    @(posedge clk);
    tick <= 1'b1;
    ir_in <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    // pulses stand from this edge to the next, so look just after it
    repeat (4) begin
      #1;
      cnt = cnt + {7'h00, sco} + {3'h0, irp, 4'h0};
      @(posedge clk);
    end
    ir_in <= 1'b0;
    chk("event_pulses", 8'h11, cnt);
    $display("test events done");
    report_and_stop;
  end
endmodule

// File: hw/uart_wake.sv
// receive-support logic: standby wake, address filter, events, irq combine
// assumes frame shifter and baud logic sit outside, same peripheral clock
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module uart_wake (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // register port
  input  wire logic [3:0]                 addr,
  input  wire logic [7:0]                 wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [7:0]                 rdata,
  // serial pin and frame shifter
  input  wire logic                       rx_pin,
  input  wire uart_wake_pkg::rx_frame_type frame_in,
  input  wire logic                       frame_busy,
  input  wire logic                       false_start,
  input  wire logic                       tx_shift_done,
  input  wire logic                       tx_buf_taken,
  input  wire logic                       autobaud_err,
  input  wire logic                       shift_clk_tick,
  // power manager
  input  wire logic                       standby,
  input  wire logic                       other_wake,
  input  wire logic                       sleep_req,
  output uart_wake_pkg::wake_out_type     wake_out,
  output logic                            osc_keep,
  // events
  input  wire logic                       infrared_event_input,
  output logic                            shift_clock_output,
  output logic                            ir_pulse,
  // interrupts
  output logic                            receive_irq_vector,
  output logic                            tx_empty_irq_vector,
  output logic                            tx_done_irq_vector
);

  //////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]  ctrl_a_reg;
  logic [7:0]  ctrl_b_reg;
  logic [7:0]  ctrl_c_reg;
  logic [15:0] baud_reg;
  logic [7:0]  ctrl_d_reg;
  logic [7:0]  dbg_reg;
  logic [7:0]  event_input_control_reg;
  logic [7:0]  txpl_reg;
  logic [7:0]  rxpl_reg;
  logic [8:0]  tx_data_reg;
  logic [8:0]  rx_data_reg;
  logic [2:0]  rx_err_reg;
  logic        receive_done_flag;
  logic        receive_start_flag;
  logic        tx_empty_flag;
  logic        tx_done_flag;
  logic        sync_field_error_flag;

  logic frame_start_wake_enable;
  logic address_filter_mode;
  logic async_mode;
  logic nine_bit;
  assign frame_start_wake_enable = ctrl_b_reg[uart_wake_pkg::cb_wake];
  assign address_filter_mode     = ctrl_b_reg[uart_wake_pkg::cb_filt];
  assign async_mode = ctrl_c_reg[7:6] == uart_wake_pkg::cmode_async;
  assign nine_bit   = ctrl_c_reg[2:0] == uart_wake_pkg::chsize_9lo
                   || ctrl_c_reg[2:0] == uart_wake_pkg::chsize_9hi;

  logic wr_ctrl;
  assign wr_ctrl = wr;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_a_reg <= uart_wake_pkg::zero_byte;
      ctrl_b_reg <= uart_wake_pkg::zero_byte;
      ctrl_c_reg <= uart_wake_pkg::zero_byte;
      baud_reg   <= 16'h0000;
      ctrl_d_reg <= uart_wake_pkg::zero_byte;
      dbg_reg    <= uart_wake_pkg::zero_byte;
      event_input_control_reg <= uart_wake_pkg::zero_byte;
      txpl_reg   <= uart_wake_pkg::zero_byte;
      rxpl_reg   <= uart_wake_pkg::zero_byte;
    end else if (wr_ctrl) begin
      case (addr)
        uart_wake_pkg::off_ctrl_a:  ctrl_a_reg <= wdata;
        uart_wake_pkg::off_ctrl_b:  ctrl_b_reg <= wdata;
        uart_wake_pkg::off_ctrl_c:  ctrl_c_reg <= wdata;
        uart_wake_pkg::off_baud_lo: baud_reg[7:0] <= wdata;
        uart_wake_pkg::off_baud_hi: baud_reg[15:8] <= wdata;
        uart_wake_pkg::off_ctrl_d:  ctrl_d_reg <= {wdata[7:6], 6'h00};
        uart_wake_pkg::off_dbg:     dbg_reg <= {7'h00, wdata[0]};
        uart_wake_pkg::off_event_input_control:  event_input_control_reg <= {7'h00, wdata[0]};
        uart_wake_pkg::off_txpl:    txpl_reg <= wdata;
        uart_wake_pkg::off_rxpl:    rxpl_reg <= {1'b0, wdata[6:0]};
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive path with address filter

  logic frame_is_addr;
  logic frame_accept;
  logic rx_pop;
  // type bit: ninth data bit, or first stop bit for short frames
  assign frame_is_addr = nine_bit ? frame_in.data[8] : frame_in.stop1;
  assign frame_accept  = frame_in.valid && (!address_filter_mode || frame_is_addr);
  assign rx_pop = rd && (nine_bit && ctrl_c_reg[2:0] == uart_wake_pkg::chsize_9lo
                         ? addr == uart_wake_pkg::off_rx_high
                         : addr == uart_wake_pkg::off_rx_low);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_data_reg <= 9'h000;
      rx_err_reg  <= 3'h0;
    end else if (frame_accept) begin
      rx_data_reg <= frame_in.data;
      rx_err_reg  <= {1'b0, frame_in.ferr, frame_in.perr};
    end
  end

  // a new frame beats the read that empties the buffer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      receive_done_flag <= 1'b0;
    end else if (frame_accept) begin
      receive_done_flag <= 1'b1;
    end else if (rx_pop) begin
      receive_done_flag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and start-of-frame wake

  logic [2:0] rx_sync_reg;
  logic       rx_fall;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_sync_reg <= 3'b111;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], rx_pin};
    end
  end
  // second and third stages agree low after agreeing high
  logic rx_level_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_level_reg <= 1'b1;
    end else if (rx_sync_reg[1] == rx_sync_reg[2]) begin
      rx_level_reg <= rx_sync_reg[2];
    end
  end
  assign rx_fall = rx_level_reg && rx_sync_reg[1] == rx_sync_reg[2] && !rx_sync_reg[2];

  logic wake_armed;
  assign wake_armed = frame_start_wake_enable && async_mode && standby;

  typedef enum logic [2:0] {
    wk_idle  = 3'b001,
    wk_frame = 3'b010,
    wk_woken = 3'b100
  } wake_state_type;

  wake_state_type wake_reg;
  wake_state_type wake_next;
  logic           rx_irq_en;
  logic           rxs_irq_en;
  assign rx_irq_en  = ctrl_a_reg[uart_wake_pkg::ca_receive_done_irq_enable];
  assign rxs_irq_en = ctrl_a_reg[uart_wake_pkg::ca_receive_start_irq_enable];

  always_comb begin
    wake_next = wake_reg;
    case (wake_reg)
      wk_idle: begin
        if (wake_armed && rx_fall) begin
          wake_next = wk_frame;
        end
      end
      wk_frame: begin
        if (false_start && !other_wake) begin
          wake_next = wk_idle;
        end else if (rxs_irq_en || (rx_irq_en && frame_accept)) begin
          wake_next = wk_woken;
        end else if (!frame_busy && !frame_in.valid && !standby) begin
          wake_next = wk_idle;
        end else if (frame_in.valid && !rx_irq_en) begin
          wake_next = wk_idle;
        end
      end
      wk_woken: begin
        if (!standby) begin
          wake_next = wk_idle;
        end
      end
      default: wake_next = wk_idle;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_reg <= wk_idle;
    end else begin
      wake_reg <= wake_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_out <= '0;
      osc_keep <= 1'b0;
    end else begin
      wake_out.osc_req  <= wake_next != wk_idle;
      wake_out.clk_en   <= wake_next != wk_idle;
      wake_out.wake_irq <= wake_next == wk_woken;
      osc_keep <= sleep_req && (frame_busy || wake_next == wk_frame);
    end
  end

  // start flag: set wins over a write-one clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      receive_start_flag <= 1'b0;
    end else if (wake_armed && rx_fall) begin
      receive_start_flag <= 1'b1;
    end else if (wr && addr == uart_wake_pkg::off_status && wdata[uart_wake_pkg::st_rxs]) begin
      receive_start_flag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit flags and autobaud error flag

  logic tx_load;
  assign tx_load = wr && (nine_bit && ctrl_c_reg[2:0] == uart_wake_pkg::chsize_9lo
                          ? addr == uart_wake_pkg::off_tx_high
                          : addr == uart_wake_pkg::off_tx_low);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_data_reg <= 9'h000;
    end else if (wr && addr == uart_wake_pkg::off_tx_low) begin
      tx_data_reg[7:0] <= wdata;
    end else if (wr && addr == uart_wake_pkg::off_tx_high) begin
      tx_data_reg[8] <= wdata[0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_empty_flag <= uart_wake_pkg::status_rst[uart_wake_pkg::st_dre];
    end else if (tx_buf_taken) begin
      tx_empty_flag <= 1'b1;
    end else if (tx_load) begin
      tx_empty_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_done_flag <= 1'b0;
    end else if (tx_shift_done && tx_empty_flag && !tx_load) begin
      tx_done_flag <= 1'b1;
    end else if (wr && addr == uart_wake_pkg::off_status && wdata[uart_wake_pkg::st_txc]) begin
      tx_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_field_error_flag <= 1'b0;
    end else if (autobaud_err) begin
      sync_field_error_flag <= 1'b1;
    end else if (wr && addr == uart_wake_pkg::off_status && wdata[uart_wake_pkg::st_isf]) begin
      sync_field_error_flag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // events

  logic host_clocked;
  assign host_clocked = ctrl_c_reg[7:6] == uart_wake_pkg::cmode_sync
                     || ctrl_c_reg[7:6] == uart_wake_pkg::cmode_spi;

  // same-clock event input, so no synchroniser; edge makes the pulse
  logic ir_prev_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_prev_reg        <= 1'b0;
      ir_pulse           <= 1'b0;
      shift_clock_output <= 1'b0;
    end else begin
      ir_prev_reg <= infrared_event_input;
      ir_pulse    <= event_input_control_reg[0] && infrared_event_input && !ir_prev_reg;
      shift_clock_output <= host_clocked && shift_clk_tick;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt combine

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      receive_irq_vector  <= 1'b0;
      tx_empty_irq_vector <= 1'b0;
      tx_done_irq_vector  <= 1'b0;
    end else begin
      receive_irq_vector <= (rx_irq_en && receive_done_flag)
                         || (rxs_irq_en && receive_start_flag)
                         || (ctrl_a_reg[uart_wake_pkg::ca_autobaud_error_irq_enable] && sync_field_error_flag);
      tx_empty_irq_vector <= ctrl_a_reg[uart_wake_pkg::ca_tx_empty_irq_enable] && tx_empty_flag;
      tx_done_irq_vector  <= ctrl_a_reg[uart_wake_pkg::ca_tx_done_irq_enable] && tx_done_flag;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= uart_wake_pkg::zero_byte;
    end else if (rd) begin
      case (addr)
        uart_wake_pkg::off_rx_low:  rdata <= rx_data_reg[7:0];
        uart_wake_pkg::off_rx_high: rdata <= {receive_done_flag, 4'h0, rx_err_reg[1:0],
                                              rx_data_reg[8]};
        uart_wake_pkg::off_tx_low:  rdata <= tx_data_reg[7:0];
        uart_wake_pkg::off_tx_high: rdata <= {7'h00, tx_data_reg[8]};
        uart_wake_pkg::off_status:  rdata <= {receive_done_flag, tx_done_flag, tx_empty_flag,
                                              receive_start_flag, sync_field_error_flag,
                                              3'h0};
        uart_wake_pkg::off_ctrl_a:  rdata <= ctrl_a_reg;
        uart_wake_pkg::off_ctrl_b:  rdata <= ctrl_b_reg;
        uart_wake_pkg::off_ctrl_c:  rdata <= ctrl_c_reg;
        uart_wake_pkg::off_baud_lo: rdata <= baud_reg[7:0];
        uart_wake_pkg::off_baud_hi: rdata <= baud_reg[15:8];
        uart_wake_pkg::off_ctrl_d:  rdata <= ctrl_d_reg;
        uart_wake_pkg::off_dbg:     rdata <= dbg_reg;
        uart_wake_pkg::off_event_input_control:  rdata <= event_input_control_reg;
        uart_wake_pkg::off_txpl:    rdata <= txpl_reg;
        uart_wake_pkg::off_rxpl:    rdata <= rxpl_reg;
        default:                    rdata <= uart_wake_pkg::zero_byte;
      endcase
    end else begin
      rdata <= uart_wake_pkg::zero_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  a_start_flag_set: assert property (@(posedge clk) disable iff (rst)
    (wake_armed && rx_fall) |=> receive_start_flag)
    else $error("start flag not set on standby start edge");

  a_start_flag_clr: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == uart_wake_pkg::off_status && wdata[uart_wake_pkg::st_rxs]
     && !(wake_armed && rx_fall)) |=> !receive_start_flag)
    else $error("start flag not cleared by write one");

  a_wake_request: assert property (@(posedge clk) disable iff (rst)
    (wake_reg == wk_idle && wake_armed && rx_fall) |=> wake_out.osc_req && wake_out.clk_en)
    else $error("no oscillator request on start edge");

  a_wake_gated: assert property (@(posedge clk) disable iff (rst)
    (wake_reg == wk_idle && !(frame_start_wake_enable && async_mode)) |=> !wake_out.osc_req)
    else $error("wake request without enable");

  a_false_release: assert property (@(posedge clk) disable iff (rst)
    (wake_reg == wk_frame && false_start && !other_wake) |=> !wake_out.osc_req)
    else $error("false start did not release wake");

  a_filter_skip: assert property (@(posedge clk) disable iff (rst)
    (address_filter_mode && frame_in.valid && !frame_is_addr && !receive_done_flag && !rx_pop)
    |=> !receive_done_flag)
    else $error("skipped data frame set receive flag");

  a_rx_accept: assert property (@(posedge clk) disable iff (rst)
    (!address_filter_mode && frame_in.valid) |=> receive_done_flag
     && rx_data_reg == $past(frame_in.data))
    else $error("frame lost with filter off");

  a_rx_irq_and: assert property (@(posedge clk) disable iff (rst)
    receive_irq_vector == $past((rx_irq_en && receive_done_flag)
      || (rxs_irq_en && receive_start_flag)
      || (ctrl_a_reg[uart_wake_pkg::ca_autobaud_error_irq_enable] && sync_field_error_flag)))
    else $error("receive irq not flag and enable");

  a_tx_done_irq: assert property (@(posedge clk) disable iff (rst)
    (tx_done_flag && ctrl_a_reg[uart_wake_pkg::ca_tx_done_irq_enable]) |=> tx_done_irq_vector)
    else $error("tx done irq missing");

  a_osc_hold: assert property (@(posedge clk) disable iff (rst)
    (sleep_req && frame_busy) |=> osc_keep)
    else $error("oscillator released mid frame");

endmodule

// File: hw/uart_wake_pkg.sv
// constants and carrier types for the serial port receive-support block
// assumes a byte-wide register port and a frame shifter outside this block
// Summary of operation
// - rx falling edge in standby with wake enabled requests oscillator and clock
// - false start with no other wake source drops request, back to standby
// - frame-start wake only in asynchronous mode, gated by control b enable bit
// - start bit seen during standby with frame-start wake enabled in asynchronous mode sets the receive-start flag
// - receive-done and receive-start share one irq line, separate enables
// - wake on start if its irq enabled, else on receive-done, else oscillator only
// - sleep request never stops oscillator while a frame is in progress
// - writing one to the filter bit in control b enters address-filter mode
// - frame type from first stop bit for 5-8 bits, ninth bit for 9
// - type one means address frame, type zero means data frame
// - filter mode skips all data frames, keeps address frames; off receives all
// - shift clock exported as peripheral-clock pulse event in host modes
// - infrared event input detected as a pulse, handled synchronously
// - receive irq from unread data, start of frame, or autobaud error, each enabled
// - tx-empty irq while enabled and transmit buffer can accept data
// - tx-done irq when enabled and shift register and buffer are empty
// - each irq is flag and enable, held until flag clears
// - flags live in status at 0x04, enables in control a at 0x05
// - receive-start flag cleared by writing one to it
// - ninth received bit shown in bit 0 of the receive high register
package uart_wake_pkg;

  localparam logic [3:0] off_rx_low    = 4'h0;
  localparam logic [3:0] off_rx_high   = 4'h1;
  localparam logic [3:0] off_tx_low    = 4'h2;
  localparam logic [3:0] off_tx_high   = 4'h3;
  localparam logic [3:0] off_status    = 4'h4;
  localparam logic [3:0] off_ctrl_a    = 4'h5;
  localparam logic [3:0] off_ctrl_b    = 4'h6;
  localparam logic [3:0] off_ctrl_c    = 4'h7;
  localparam logic [3:0] off_baud_lo   = 4'h8;
  localparam logic [3:0] off_baud_hi   = 4'h9;
  localparam logic [3:0] off_ctrl_d    = 4'ha;
  localparam logic [3:0] off_dbg       = 4'hb;
  localparam logic [3:0] off_event_input_control    = 4'hc;
  localparam logic [3:0] off_txpl      = 4'hd;
  localparam logic [3:0] off_rxpl      = 4'he;

  // status bits
  localparam int st_rxc = 7;
  localparam int st_txc = 6;
  localparam int st_dre = 5;
  localparam int st_rxs = 4;
  localparam int st_isf = 3;
  // control a bits
  localparam int ca_receive_done_irq_enable = 7;
  localparam int ca_tx_done_irq_enable = 6;
  localparam int ca_tx_empty_irq_enable = 5;
  localparam int ca_receive_start_irq_enable = 4;
  localparam int ca_autobaud_error_irq_enable = 2;
  // control b bits
  localparam int cb_wake  = 4;
  localparam int cb_mode0 = 1;
  localparam int cb_filt  = 0;
  // control c fields
  localparam int cc_cmode0 = 6;
  localparam int cc_sbmode = 3;
  localparam logic [1:0] cmode_async = 2'h0;
  localparam logic [1:0] cmode_sync  = 2'h1;
  localparam logic [1:0] cmode_spi   = 2'h3;
  localparam logic [2:0] chsize_9lo  = 3'h6;
  localparam logic [2:0] chsize_9hi  = 3'h7;
  localparam int rxh_data8 = 0;

  localparam logic [7:0] status_rst = 8'h20;
  localparam logic [7:0] zero_byte  = 8'h00;

  // one frame from the shifter
  typedef struct packed {
    logic       valid;
    logic [8:0] data;
    logic       stop1;
    logic       ferr;
    logic       perr;
  } rx_frame_type;

  // power manager handshake
  typedef struct packed {
    logic osc_req;
    logic clk_en;
    logic wake_irq;
  } wake_out_type;

endpackage
